// file: hw/car_router.sv
/*
 * Configuration access router: turns host I/O port and enhanced window
 * accesses into one internal request and picks its destination.
 * Assumes host requests are synchronous one-cycle pulses on clock and the
 * window base/size/enables arrive from the internal device registers.
 */
`default_nettype none

// Overview of operation
// - Dword write to address port latches target
// - Bit 31 set enables configuration cycles
// - Data port access becomes configuration cycle
// - Eight functions, 256 registers each
// - Each function owns 4096 bytes space
// - Extended region only through memory window
// - Window base lies below 4GB
// - Window size 256, 128 or 64MB
// - Separate winEnable bit enables enhanced window
// - Offset decodes bus, device, function, register
// - Four-bit extended index, zero when compatible
// - Both mechanisms yield one request format
// - Internal functions answer on bus 0
// - Other bus-0 and downstream go media link
// - Graphics link spaces go graphics port
// - Claim dev 0 fn 0; dev 1 fn 0 when gportEn set
// - Claim dev 2 fn 0 when gfxFun0En set; fn 1 needs gfxFun1En too
// - Bus in bridge range: graphics Type 1
// - Secondary bus dev 0 Type 0, else abort
// - Unclaimed go downstream Type 0 or 1
// - Non-dword address port access passes downstream
// - Bus number from address port 23:16

module car_router
	import car_pkg::*;
(
	// Clock and reset
	input  wire  logic               clock,
	input  wire  logic               arst_n,
	// Host processor bus side
	input  wire  car_pkg::car_host_t hostReq,
	input  wire  car_pkg::car_cfg_t  cfgIn,
	output var   logic [31:0]        addrPortRd,
	output var   logic               ioPassValid,
	output var   car_pkg::car_host_t ioPassReq,
	// Routed configuration request
	output var   logic               cfgValid,
	output var   car_pkg::car_req_t  cfgReq,
	output var   car_pkg::car_route_t cfgRoute
);
	import car_pkg::*;

	// ----------------------------------------------------------------
	// Local field widths and masks
	// ----------------------------------------------------------------
	localparam int          PORT_SEL_HI = 15;
	localparam int          PORT_SEL_LO = 2;
	localparam int          BUS_W       = 8;
	localparam int          DEV_W       = 5;
	localparam int          FUN_W       = 3;
	localparam logic [31:0] ALL_ONES    = 32'hffff_ffff;
	localparam logic [7:0]  BUS_ALL_256 = 8'hff;
	localparam logic [7:0]  BUS_ALL_128 = 8'h7f;
	localparam logic [7:0]  BUS_ALL_64  = 8'h3f;

	// ----------------------------------------------------------------
	// Address port decode
	// ----------------------------------------------------------------
	logic [31:0] addrPort_ff;
	logic [31:0] nxt_addrPort;
	wire         ioHit     = hostReq.valid && hostReq.isIo;
	wire         addrHit   = ioHit && (hostReq.addr[PORT_SEL_HI:PORT_SEL_LO] ==
	                         CAR_ADDR_PORT_IO[PORT_SEL_HI:PORT_SEL_LO]);
	wire         dataHit   = ioHit && (hostReq.addr[PORT_SEL_HI:PORT_SEL_LO] ==
	                         CAR_DATA_PORT_IO[PORT_SEL_HI:PORT_SEL_LO]);
	wire         addrDword = hostReq.byteEn == CAR_BE_DWORD;
	wire         addrWrite = addrHit && hostReq.write && addrDword;
	wire         addrPass  = addrHit && !addrDword;
	wire         portEn    = addrPort_ff[CAR_ENABLE_BIT];
	wire         dataPass  = dataHit && !portEn;
	wire         portCfg   = dataHit && portEn;

	assign nxt_addrPort = addrWrite ? hostReq.data : addrPort_ff;

	// ----------------------------------------------------------------
	// Enhanced window decode
	// ----------------------------------------------------------------
	// Size selects decode width
	logic [31:0] winMask;
	logic [7:0]  busMask;
	always_comb begin
		unique case (cfgIn.winSize)
			CAR_WIN_128MB: begin
				winMask = ALL_ONES << CAR_WIN_SHIFT_128;
				busMask = BUS_ALL_128;
			end
			CAR_WIN_64MB: begin
				winMask = ALL_ONES << CAR_WIN_SHIFT_64;
				busMask = BUS_ALL_64;
			end
			default: begin
				winMask = ALL_ONES << CAR_WIN_SHIFT_256;
				busMask = BUS_ALL_256;
			end
		endcase
	end

	// Base held in 32 bits, below 4GB
	wire [31:0] winOff = hostReq.addr & ~winMask;
	wire        winHit = hostReq.valid && !hostReq.isIo && cfgIn.winEnable &&
	                     ((hostReq.addr & winMask) == (cfgIn.winBase & winMask));

	// ----------------------------------------------------------------
	// Common request build
	// ----------------------------------------------------------------
	car_req_t portReq;
	car_req_t winReq;

	assign portReq.write  = hostReq.write;
	assign portReq.bus    = addrPort_ff[CAR_BUS_HI:CAR_BUS_LO];
	assign portReq.dev    = addrPort_ff[CAR_DEV_HI:CAR_DEV_LO];
	assign portReq.fun    = addrPort_ff[CAR_FUN_HI:CAR_FUN_LO];
	assign portReq.extReg = CAR_EXT_ZERO;
	assign portReq.regDw  = addrPort_ff[CAR_REG_HI:CAR_REG_LO];
	assign portReq.byteEn = hostReq.byteEn;
	assign portReq.data   = hostReq.data;

	assign winReq.write  = hostReq.write;
	assign winReq.bus    = winOff[CAR_WIN_BUS_LO +: BUS_W] & busMask;
	assign winReq.dev    = winOff[CAR_WIN_DEV_LO +: DEV_W];
	assign winReq.fun    = winOff[CAR_WIN_FUN_LO +: FUN_W];
	assign winReq.extReg = winOff[CAR_WIN_EXT_HI:CAR_WIN_EXT_LO];
	assign winReq.regDw  = winOff[CAR_REG_HI:CAR_REG_LO];
	assign winReq.byteEn = hostReq.byteEn;
	assign winReq.data   = hostReq.data;

	wire      reqValid = portCfg || winHit;
	car_req_t req;
	assign req = portCfg ? portReq : winReq;

	// ----------------------------------------------------------------
	// Routing
	// ----------------------------------------------------------------
	wire busZero  = req.bus == CAR_BUS_ZERO;
	wire busSec   = !busZero && (req.bus == cfgIn.secBus);
	wire busRange = !busZero && (req.bus > cfgIn.secBus) && (req.bus <= cfgIn.subBus);

	wire claimHost  = req.dev == CAR_DEV_HOST && req.fun == CAR_FUN_0;
	wire claimGport = req.dev == CAR_DEV_GPORT && req.fun == CAR_FUN_0 && cfgIn.gportEn;
	wire claimGfx0  = req.dev == CAR_DEV_GFX && req.fun == CAR_FUN_0 && cfgIn.gfxFun0En;
	wire claimGfx1  = req.dev == CAR_DEV_GFX && req.fun == CAR_FUN_1 &&
	                  cfgIn.gfxFun0En && cfgIn.gfxFun1En;
	wire claimInt   = busZero && (claimHost || claimGport || claimGfx0 || claimGfx1);

	car_route_t route;
	always_comb begin
		if (claimInt) begin
			route = CAR_RT_INTERNAL;
		end else if (busZero) begin
			route = CAR_RT_DML_T0;
		end else if (busSec) begin
			route = (req.dev == CAR_DEV_HOST) ? CAR_RT_GFX_T0 : CAR_RT_DML_ABORT;
		end else if (busRange) begin
			route = CAR_RT_GFX_T1;
		end else begin
			route = CAR_RT_DML_T1;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic       cfgValid_ff;
	car_req_t   cfgReq_ff;
	car_route_t cfgRoute_ff;
	logic       ioPassValid_ff;
	car_host_t  ioPassReq_ff;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			addrPort_ff <= CAR_ADDR_PORT_RST;
		end else begin
			addrPort_ff <= nxt_addrPort;
		end
	end

	// Configuration pulse, one per taken request
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cfgValid_ff <= 1'b0;
		end else begin
			cfgValid_ff <= reqValid;
		end
	end

	// Payload follows every cycle; only meaningful under the pulse
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cfgReq_ff <= '0;
		end else begin
			cfgReq_ff <= req;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cfgRoute_ff <= CAR_RT_INTERNAL;
		end else begin
			cfgRoute_ff <= route;
		end
	end

	// Plain I/O pass-through pulse
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ioPassValid_ff <= 1'b0;
		end else begin
			ioPassValid_ff <= addrPass || dataPass;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ioPassReq_ff <= '0;
		end else begin
			ioPassReq_ff <= hostReq;
		end
	end

	assign addrPortRd  = addrPort_ff;
	assign cfgValid    = cfgValid_ff;
	assign cfgReq      = cfgReq_ff;
	assign cfgRoute    = cfgRoute_ff;
	assign ioPassValid = ioPassValid_ff;
	assign ioPassReq   = ioPassReq_ff;

endmodule : car_router

`default_nettype wire

// file: hw/car_pkg.sv
/*
 * Package for the configuration access router: port addresses, address field
 * positions, window sizes, route codes and the common request format.
 * Assumes a single host clock domain; all users import the whole package.
 */
`default_nettype none

package car_pkg;

	// ----------------------------------------------------------------
	// I/O port addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] CAR_ADDR_PORT_IO  = 16'h0cf8;
	localparam logic [15:0] CAR_DATA_PORT_IO  = 16'h0cfc;
	localparam logic [3:0]  CAR_BE_DWORD      = 4'hf;
	localparam logic [31:0] CAR_ADDR_PORT_RST = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Address port fields
	// ----------------------------------------------------------------
	localparam int CAR_ENABLE_BIT = 31;
	localparam int CAR_BUS_HI     = 23;
	localparam int CAR_BUS_LO     = 16;
	localparam int CAR_DEV_HI     = 15;
	localparam int CAR_DEV_LO     = 11;
	localparam int CAR_FUN_HI     = 10;
	localparam int CAR_FUN_LO     = 8;
	localparam int CAR_REG_HI     = 7;
	localparam int CAR_REG_LO     = 2;

	// ----------------------------------------------------------------
	// Enhanced window offset fields (bus*1MB, dev*32KB, fn*4KB)
	// ----------------------------------------------------------------
	localparam int CAR_WIN_BUS_LO = 20;
	localparam int CAR_WIN_DEV_LO = 15;
	localparam int CAR_WIN_FUN_LO = 12;
	localparam int CAR_WIN_EXT_LO = 8;
	localparam int CAR_WIN_EXT_HI = 11;

	// Window size select codes
	localparam logic [1:0] CAR_WIN_256MB = 2'h0;
	localparam logic [1:0] CAR_WIN_128MB = 2'h1;
	localparam logic [1:0] CAR_WIN_64MB  = 2'h2;
	localparam int CAR_WIN_SHIFT_256 = 28;
	localparam int CAR_WIN_SHIFT_128 = 27;
	localparam int CAR_WIN_SHIFT_64  = 26;

	// Internal device numbers on bus 0
	localparam logic [4:0] CAR_DEV_HOST  = 5'h00;
	localparam logic [4:0] CAR_DEV_GPORT = 5'h01;
	localparam logic [4:0] CAR_DEV_GFX   = 5'h02;
	localparam logic [2:0] CAR_FUN_0     = 3'h0;
	localparam logic [2:0] CAR_FUN_1     = 3'h1;
	localparam logic [7:0] CAR_BUS_ZERO  = 8'h00;
	localparam logic [3:0] CAR_EXT_ZERO  = 4'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CAR_RT_INTERNAL,
		CAR_RT_GFX_T0,
		CAR_RT_GFX_T1,
		CAR_RT_DML_T0,
		CAR_RT_DML_T1,
		CAR_RT_DML_ABORT
	} car_route_t;

	// Common internal configuration request
	typedef struct packed {
		logic       write;
		logic [7:0] bus;
		logic [4:0] dev;
		logic [2:0] fun;
		logic [3:0] extReg;
		logic [5:0] regDw;
		logic [3:0] byteEn;
		logic [31:0] data;
	} car_req_t;

	// Host processor bus request
	typedef struct packed {
		logic        valid;
		logic        isIo;
		logic        write;
		logic [31:0] addr;
		logic [3:0]  byteEn;
		logic [31:0] data;
	} car_host_t;

	// Bridge and enable configuration from the internal devices
	typedef struct packed {
		logic        winEnable;
		logic [31:0] winBase;
		logic [1:0]  winSize;
		logic        gportEn;
		logic        gfxFun0En;
		logic        gfxFun1En;
		logic [7:0]  secBus;
		logic [7:0]  subBus;
	} car_cfg_t;

endpackage : car_pkg

`default_nettype wire

// file: sim/car_router_sva.sv
/* Checker for car_router: port-level properties of the request path.
 * Assumes cfgIn stays steady while requests are in flight. */
`default_nettype none

module car_router_sva
	import car_pkg::*;
(
	// Clock and reset
	input wire logic                clock,
	input wire logic                arst_n,
	// Watched ports
	input wire car_pkg::car_host_t  hostReq,
	input wire car_pkg::car_cfg_t   cfgIn,
	input wire logic [31:0]         addrPortRd,
	input wire logic                ioPassValid,
	input wire car_pkg::car_host_t  ioPassReq,
	input wire logic                cfgValid,
	input wire car_pkg::car_req_t   cfgReq,
	input wire car_pkg::car_route_t cfgRoute
);
	timeunit 1ns;
	timeprecision 1ns;
	import car_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	wire ioHit = hostReq.valid && hostReq.isIo;
	wire aHit  = ioHit && hostReq.addr[15:2] == CAR_ADDR_PORT_IO[15:2];
	wire dHit  = ioHit && hostReq.addr[15:2] == CAR_DATA_PORT_IO[15:2];
	sequence s_addrSel;
		aHit && hostReq.write && hostReq.byteEn == CAR_BE_DWORD;
	endsequence
	sequence s_dataOn;
		dHit && addrPortRd[CAR_ENABLE_BIT];
	endsequence
	a_addr_latch: assert property (s_addrSel |=> addrPortRd == $past(hostReq.data))
		else $error("address port not latched");
	a_data_cfg: assert property (s_dataOn |=> cfgValid && !ioPassValid)
		else $error("data port access gave no config cycle");
	a_data_off: assert property (dHit && !addrPortRd[CAR_ENABLE_BIT] |=> ioPassValid && !cfgValid)
		else $error("disabled data port access not passed");
	a_part_pass: assert property (aHit && hostReq.byteEn != CAR_BE_DWORD
		|=> ioPassValid && $stable(addrPortRd)) else $error("partial access mishandled");
	a_bus_field: assert property (s_dataOn
		|=> cfgReq.bus == $past(addrPortRd[23:16]) && cfgReq.extReg == CAR_EXT_ZERO)
		else $error("bus or extended field wrong");
	a_idle_quiet: assert property (!hostReq.valid |=> !cfgValid && !ioPassValid)
		else $error("pulse without request");
	a_sec_abort: assert property (cfgValid && cfgReq.bus == cfgIn.secBus
		&& cfgReq.bus != 0 && cfgReq.dev != 0 |-> cfgRoute == CAR_RT_DML_ABORT)
		else $error("secondary bus device not aborted");
	a_range_t1: assert property (cfgValid && cfgReq.bus > cfgIn.secBus
		&& cfgReq.bus <= cfgIn.subBus |-> cfgRoute == CAR_RT_GFX_T1)
		else $error("bridge range not type 1");
	a_bus0_dml: assert property (cfgValid && cfgReq.bus == 0
		&& cfgReq.dev > CAR_DEV_GFX |-> cfgRoute == CAR_RT_DML_T0)
		else $error("bus 0 outsider not type 0 downstream");
endmodule : car_router_sva

bind car_router car_router_sva u_sva (.clock(clock), .arst_n(arst_n), .hostReq(hostReq),
	.cfgIn(cfgIn), .addrPortRd(addrPortRd), .ioPassValid(ioPassValid),
	.ioPassReq(ioPassReq), .cfgValid(cfgValid), .cfgReq(cfgReq), .cfgRoute(cfgRoute));

`default_nettype wire

// file: sim/car_host_model.sv
/* Host processor model: one-cycle I/O and memory requests.
 * Assumes issue() is called at a falling clock edge. */
`default_nettype none

module car_host_model
	import car_pkg::*;
(
	input wire logic               clock,
	output var car_pkg::car_host_t hostReq
);
	timeunit 1ns;
	timeprecision 1ns;
	import car_pkg::*;
	initial hostReq = '0;
	task automatic issue(input logic io, wr, input logic [31:0] a,
		input logic [3:0] be, input logic [31:0] d);
		@(negedge clock);
		hostReq <= '{1'b1, io, wr, a, be, d};
		@(negedge clock);
		// Released bus shows inverted values so stale data cannot match
		hostReq <= '{1'b0, !io, !wr, ~a, ~be, ~d};
	endtask : issue
endmodule : car_host_model

`default_nettype wire

// file: sim/car_router_test.sv
/* Self-checking bench for car_router, host model on the request side.
 * Assumes the checker binds itself into the design. */
`default_nettype none

module car_router_test
	import car_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	import car_pkg::*;
	localparam logic [31:0] ADDR_IO = {16'h0000, CAR_ADDR_PORT_IO};
	localparam logic [31:0] DATA_IO = {16'h0000, CAR_DATA_PORT_IO};
	logic        clock = 1'b0;
	logic        arst_n = 1'b0;
	car_cfg_t    cfgIn;
	car_host_t   hostReq, ioPassReq;
	logic [31:0] addrPortRd;
	logic        ioPassValid, cfgValid;
	car_req_t    cfgReq;
	car_route_t  cfgRoute;
	int          fails = 0, n_compared = 0, cycles = 0;

	always #10 clock = ~clock;
	car_host_model u_host (.clock(clock), .hostReq(hostReq));
	car_router u_dut (.clock(clock), .arst_n(arst_n), .hostReq(hostReq), .cfgIn(cfgIn),
		.addrPortRd(addrPortRd), .ioPassValid(ioPassValid), .ioPassReq(ioPassReq),
		.cfgValid(cfgValid), .cfgReq(cfgReq), .cfgRoute(cfgRoute));

	task automatic chk(input logic [63:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_routes;
		logic [31:0] sel [9] = '{32'h8000_00fc, 32'h8000_0800, 32'h8000_1000,
			32'h8000_1100, 32'h8000_1800, 32'h8001_0000, 32'h8001_2000,
			32'h8003_0000, 32'h8004_0000};
		car_route_t rt [9] = '{CAR_RT_INTERNAL, CAR_RT_INTERNAL, CAR_RT_INTERNAL,
			CAR_RT_DML_T0, CAR_RT_DML_T0, CAR_RT_GFX_T0, CAR_RT_DML_ABORT,
			CAR_RT_GFX_T1, CAR_RT_DML_T1};
		for (int i = 0; i < 9; i++) begin
			u_host.issue(1'b1, 1'b1, ADDR_IO, CAR_BE_DWORD, sel[i]);
			chk(addrPortRd, sel[i]);
			u_host.issue(1'b1, 1'b0, DATA_IO, CAR_BE_DWORD, 32'h0000_0000);
			chk({cfgValid, cfgReq.bus, cfgReq.dev, cfgReq.fun}, {1'b1, sel[i][23:8]});
			chk({cfgReq.extReg, cfgReq.regDw}, {4'h0, sel[i][7:2]});
			chk(cfgRoute, rt[i]);
		end
	endtask : t_routes

	task automatic t_off;
		u_host.issue(1'b1, 1'b1, ADDR_IO, 4'h3, 32'h8000_0000);
		chk({ioPassValid, addrPortRd}, {1'b1, 32'h8004_0000});
		u_host.issue(1'b1, 1'b1, ADDR_IO, CAR_BE_DWORD, 32'h0000_0800);
		u_host.issue(1'b1, 1'b1, DATA_IO, CAR_BE_DWORD, 32'h1234_5678);
		chk({ioPassValid, cfgValid, ioPassReq.data}, {2'b10, 32'h1234_5678});
	endtask : t_off

	task automatic t_win;
		cfgIn.winEnable = 1'b1;
		u_host.issue(1'b0, 1'b1, 32'he011_d104, 4'h3, 32'hcafe_0001);
		chk({cfgValid, cfgReq}, {2'b11, 8'h01, 5'h03, 3'h5, 4'h1, 6'h01, 4'h3,
			32'hcafe_0001});
		chk(cfgRoute, CAR_RT_DML_ABORT);
		cfgIn.winSize = CAR_WIN_64MB;
		u_host.issue(1'b0, 1'b0, 32'he410_0000, CAR_BE_DWORD, 32'h0000_0000);
		chk({cfgValid, ioPassValid}, 2'b00);
		u_host.issue(1'b0, 1'b0, 32'he3f0_0000, CAR_BE_DWORD, 32'h0000_0000);
		chk({cfgValid, cfgReq.bus, cfgRoute}, {1'b1, 8'h3f, CAR_RT_DML_T1});
		cfgIn.winSize = CAR_WIN_128MB;
		u_host.issue(1'b0, 1'b0, 32'he800_0000, CAR_BE_DWORD, 32'h0000_0000);
		chk({cfgValid, ioPassValid}, 2'b00);
		u_host.issue(1'b0, 1'b0, 32'he7f0_0000, CAR_BE_DWORD, 32'h0000_0000);
		chk({cfgValid, cfgReq.bus, cfgRoute}, {1'b1, 8'h7f, CAR_RT_DML_T1});
		cfgIn.winEnable = 1'b0;
		u_host.issue(1'b0, 1'b0, 32'he010_0000, CAR_BE_DWORD, 32'h0000_0000);
		chk({cfgValid, ioPassValid}, 2'b00);
	endtask : t_win

	task automatic t_enables;
		cfgIn.gfxFun1En = 1'b1;
		u_host.issue(1'b1, 1'b1, ADDR_IO, CAR_BE_DWORD, 32'h8000_1100);
		u_host.issue(1'b1, 1'b0, DATA_IO, CAR_BE_DWORD, 32'h0000_0000);
		chk({cfgValid, cfgRoute}, {1'b1, CAR_RT_INTERNAL});
		cfgIn.gportEn = 1'b0;
		u_host.issue(1'b1, 1'b1, ADDR_IO, CAR_BE_DWORD, 32'h8000_0800);
		u_host.issue(1'b1, 1'b0, DATA_IO, CAR_BE_DWORD, 32'h0000_0000);
		chk({cfgValid, cfgRoute}, {1'b1, CAR_RT_DML_T0});
		cfgIn.gportEn = 1'b1;
		cfgIn.gfxFun1En = 1'b0;
	endtask : t_enables

	// Mid-run reset must drop the enable bit again
	task automatic t_reset;
		arst_n = 1'b0;
		repeat (2) @(negedge clock);
		chk({addrPortRd, cfgValid, ioPassValid, cfgRoute}, {34'h0, CAR_RT_INTERNAL});
		arst_n = 1'b1;
		u_host.issue(1'b1, 1'b0, DATA_IO, CAR_BE_DWORD, 32'h0000_0000);
		chk({ioPassValid, cfgValid}, 2'b10);
	endtask : t_reset

	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			complete_run();
		end
	end

	initial begin
		cfgIn = '{1'b0, 32'he000_0000, CAR_WIN_256MB, 1'b1, 1'b1, 1'b0, 8'h01, 8'h03};
		repeat (6) @(negedge clock);
		arst_n = 1'b1;
		chk({addrPortRd, cfgValid, cfgRoute}, {33'h0, CAR_RT_INTERNAL});
		t_routes();
		t_off();
		t_enables();
		t_win();
		t_reset();
		complete_run();
	end
endmodule : car_router_test

`default_nettype wire
